// file: include/prio_intr_defines.svh
/*
 Input count, board number width and address-byte layout for the priority interrupt board.
 Assumes inclusion by bare name from the design files.
*/
`ifndef PRIO_INTR_DEFINES_SVH
`define PRIO_INTR_DEFINES_SVH
`define INPUT_COUNT 8
`define BOARD_ID_WIDTH 3
`define BASE_ADDR_RESET 8'h00
`define ADDR_SLOT_LSB 0
`define ADDR_BOARD_LSB 3
`endif

// file: include/prio_intr_pkg.sv
/*
 Types shared by the priority interrupt board files.
 Assumes the defines header is on the include path.
*/
`include "prio_intr_defines.svh"
package prio_intr_pkg;
   typedef logic [`INPUT_COUNT-1:0] line_vec_t;
   typedef logic [7:0] byte_t;
   typedef enum logic [1:0] {ST_IDLE, ST_REQ, ST_SEND} chain_st_e;
endpackage : prio_intr_pkg

// file: verilog/prio_sync_latch.sv
/*
 Two-flop synchroniser, rising-edge detect and pending store per input.
 Assumes asynchronous external lines and one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module prio_sync_latch
   import prio_intr_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire line_vec_t lines,
   input wire line_vec_t enable,
   input wire line_vec_t clear,
   output line_vec_t pending
);
   line_vec_t s1_q, s2_q, s3_q, pend_q, pend_d;

   // Pending set by enabled rising edge; set wins over clear
   always_comb begin
      pend_d = (pend_q & ~clear) | (s2_q & ~s3_q & enable);
   end

   // Synchroniser, edge history and store
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         pend_q <= '0;
      end else begin
         s1_q <= lines;
         s2_q <= s1_q;
         s3_q <= s2_q;
         pend_q <= pend_d;
      end
   end

   assign pending = pend_q & enable;
endmodule : prio_sync_latch
`default_nettype wire

// file: verilog/prio_intr_board.sv
/*
 Eight-input daisy-chain priority interrupt board.
 Holds the pin synchronisers, the pending store (in a small module of its
 own), the ranking of pending inputs, the chain state machine and the
 address byte register that answers an acknowledge.
 A transfer runs: priority arrives, a pending input blocks the chain and
 pulls the shared request line, the processor raises acknowledge, the
 board loads the address byte, the processor strobes it off the bus, and
 the board drops its request and clears the served input.
 Assumes interrupt request line is wired-OR open drain, acknowledge from the
 processor is a level on a pin, and the processor takes the address byte
 with a read strobe pin while acknowledge is high.
 Assumes a fresh acknowledge for every request: only a rising acknowledge
 is taken, so an acknowledge still held high from the last transfer cannot start
 the next one.
 Board number is static and needs no synchroniser.
*/
`timescale 1ns/1ps
`default_nettype none
`include "prio_intr_defines.svh"
module prio_intr_board
   import prio_intr_pkg::*;
(
   input wire logic CLK,
   input wire logic RESET,
   input wire line_vec_t IRQ_LINES,
   input wire line_vec_t IRQ_ENABLE,
   input wire logic [`BOARD_ID_WIDTH-1:0] BOARD_ID,
   input wire logic PRIO_IN,
   output logic PRIO_OUT,
   input wire logic IRQ_REQ_IN,
   output logic IRQ_REQ_OUT,
   output logic IRQ_REQ_OE,
   input wire logic ACK,
   input wire logic ADDR_STROBE,
   output byte_t BUS_DATA,
   output logic BUS_OE,
   output logic BUSY
);
   line_vec_t pending; // Enabled and stored events
   line_vec_t clear_vec; // One-hot clear of the served input
   logic pend_any; // Something waits on this board
   logic [1:0] prio_sync_q; // Priority pin, two flops
   logic [1:0] prio_sync_d;
   logic [2:0] ack_sync_q; // Acknowledge pin, two flops and edge history
   logic [2:0] ack_sync_d;
   logic [2:0] stb_sync_q; // Strobe pin, two flops and edge history
   logic [2:0] stb_sync_d;
   logic prio_in_s;
   logic ack_s;
   logic ack_rise;
   logic stb_s;
   logic stb_rise;
   logic [2:0] win_idx; // Highest ranked pending input
   chain_st_e st_q;
   chain_st_e st_d;
   logic [2:0] sel_q;
   logic [2:0] sel_d;
   byte_t data_q;
   byte_t data_d;
   logic load_addr; // Take the address byte this cycle

   // Lowest numbered pending input wins
   function automatic logic [2:0] first_set(input line_vec_t v);
      logic [2:0] idx;
      idx = 3'h0;
      for (int i = `INPUT_COUNT - 1; i >= 0; i--) begin
         if (v[i]) begin
            idx = i[2:0];
         end
      end
      return idx;
   endfunction : first_set

   // Service address: board number above slot number
   function automatic byte_t make_addr(input logic [2:0] board, input logic [2:0] slot);
      byte_t a;
      a = `BASE_ADDR_RESET;
      a[`ADDR_BOARD_LSB +: 3] = board;
      a[`ADDR_SLOT_LSB +: 3] = slot;
      return a;
   endfunction : make_addr

   // Input store with per-input enable
   prio_sync_latch u_latch (
      .clk(CLK),
      .reset(RESET),
      .lines(IRQ_LINES),
      .enable(IRQ_ENABLE),
      .clear(clear_vec),
      .pending(pending)
   );

   // Next values of the pin synchronisers
   always_comb begin
      prio_sync_d = {prio_sync_q[0], PRIO_IN};
      ack_sync_d = {ack_sync_q[1:0], ACK};
      stb_sync_d = {stb_sync_q[1:0], ADDR_STROBE};
   end

   // Pin synchronisers
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         prio_sync_q <= 2'h0;
         ack_sync_q <= 3'h0;
         stb_sync_q <= 3'h0;
      end else begin
         prio_sync_q <= prio_sync_d;
         ack_sync_q <= ack_sync_d;
         stb_sync_q <= stb_sync_d;
      end
   end

   // Synchronised levels and rising edges; edges compare the second flop with the third
   assign prio_in_s = prio_sync_q[1];
   assign ack_s = ack_sync_q[1];
   assign ack_rise = ack_sync_q[1] & ~ack_sync_q[2];
   assign stb_s = stb_sync_q[1];
   assign stb_rise = stb_sync_q[1] & ~stb_sync_q[2];

   // Rank pending inputs
   assign pend_any = (pending != '0);
   assign win_idx = first_set(pending);

   // Chain state: idle, requesting, sending address
   always_comb begin
      st_d = st_q;
      load_addr = 1'b0;
      clear_vec = '0;
      case (st_q)
         ST_IDLE: begin
            if (prio_in_s && pend_any) begin
               st_d = ST_REQ;
            end
         end
         ST_REQ: begin
            if (!pend_any) begin
               st_d = ST_IDLE;
            end else if (ack_rise) begin
               st_d = ST_SEND;
               load_addr = 1'b1;
            end else if (!prio_in_s) begin
               st_d = ST_IDLE;
            end
         end
         ST_SEND: begin
            if (stb_rise || !ack_s) begin
               st_d = ST_IDLE;
               clear_vec[sel_q] = stb_rise;
            end
         end
         default: begin
            st_d = ST_IDLE;
         end
      endcase
   end

   // Selection follows the winner until the address byte is loaded, then holds while it is out
   always_comb begin
      sel_d = sel_q;
      if (st_q != ST_SEND) begin
         sel_d = win_idx;
      end
   end

   // Address byte, loaded once per acknowledge
   always_comb begin
      data_d = data_q;
      if (load_addr) begin
         data_d = make_addr(BOARD_ID, win_idx);
      end
   end

   // Chain state register
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         st_q <= ST_IDLE;
      end else begin
         st_q <= st_d;
      end
   end

   // Selection register
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         sel_q <= 3'h0;
      end else begin
         sel_q <= sel_d;
      end
   end

   // Address byte register
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         data_q <= `BASE_ADDR_RESET;
      end else begin
         data_q <= data_d;
      end
   end

   // Chain and bus outputs
   assign BUSY = (st_q != ST_IDLE);
   assign PRIO_OUT = prio_in_s & ~pend_any & (st_q == ST_IDLE);
   assign IRQ_REQ_OUT = 1'b0;
   assign IRQ_REQ_OE = (st_q != ST_IDLE);
   assign BUS_OE = (st_q == ST_SEND) & stb_s;
   assign BUS_DATA = data_q;

   logic unused_req;
   assign unused_req = IRQ_REQ_IN;
endmodule : prio_intr_board
`default_nettype wire

// file: dv/prio_intr_checker.sv
/* Port assertions for the priority interrupt board.
   Assumes bind onto prio_intr_board, one clock domain. */
`timescale 1ns/1ps
`default_nettype none
`include "prio_intr_defines.svh"
module prio_intr_checker
   import prio_intr_pkg::*;
(
   input wire logic CLK,
   input wire logic RESET,
   input wire line_vec_t IRQ_ENABLE,
   input wire logic [`BOARD_ID_WIDTH-1:0] BOARD_ID,
   input wire logic PRIO_OUT,
   input wire logic IRQ_REQ_OUT,
   input wire logic IRQ_REQ_OE,
   input wire byte_t BUS_DATA,
   input wire logic BUS_OE,
   input wire logic BUSY
);
   // Sampled on CLK, quiet during reset
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RESET);
   a_pin_pulls_low: assert property (IRQ_REQ_OUT == 1'b0)
      else $error("Request pin not pulled low");
   a_req_blocks: assert property (IRQ_REQ_OE |-> !PRIO_OUT)
      else $error("Priority passed while requesting");
   a_busy_blocks: assert property (BUSY |-> !PRIO_OUT)
      else $error("Priority passed while busy");
   a_req_busy: assert property (IRQ_REQ_OE |-> BUSY)
      else $error("Request without busy");
   a_req_enabled: assert property ($rose(IRQ_REQ_OE) |-> $past(IRQ_ENABLE) != 8'h00)
      else $error("Request with all inputs off");
   a_addr_byte: assert property (BUS_OE |-> BUS_DATA[7:3] == {2'b00, BOARD_ID})
      else $error("Address byte malformed");
   a_req_held: assert property ($rose(BUS_OE) |-> IRQ_REQ_OE)
      else $error("Request dropped before transfer");
   a_release: assert property ($rose(BUS_OE) |=> !BUS_OE && !IRQ_REQ_OE)
      else $error("Request not released after transfer");
   // Main scenarios
   c_req: cover property ($rose(IRQ_REQ_OE));
   c_send: cover property ($rose(BUS_OE));
   c_block: cover property (PRIO_OUT ##1 !PRIO_OUT);
endmodule : prio_intr_checker
bind prio_intr_board prio_intr_checker u_chk (.CLK(CLK), .RESET(RESET),
   .IRQ_ENABLE(IRQ_ENABLE), .BOARD_ID(BOARD_ID), .PRIO_OUT(PRIO_OUT),
   .IRQ_REQ_OUT(IRQ_REQ_OUT), .IRQ_REQ_OE(IRQ_REQ_OE), .BUS_DATA(BUS_DATA),
   .BUS_OE(BUS_OE), .BUSY(BUSY));
`default_nettype wire

// file: dv/proc_model.sv
/* Processor model: acknowledges the shared request, strobes the byte.
   Assumes the request wire is low while any board pulls it. */
`timescale 1ns/1ps
`default_nettype none
module proc_model (
   input wire logic clk,
   input wire logic req_n,
   output logic ack,
   output logic strobe
);
   int n;
   // Answer each request after a random delay
   initial begin
      ack = 1'b0;
      strobe = 1'b0;
      forever begin
         @(posedge clk);
         if (req_n === 1'b0) begin
            repeat ($urandom_range(4)) @(posedge clk);
            ack <= 1'b1;
            repeat (5) @(posedge clk);
            strobe <= 1'b1;
            n = 0;
            while (req_n === 1'b0 && n < 20) begin
               @(posedge clk);
               n++;
            end
            ack <= 1'b0;
            strobe <= 1'b0;
            @(posedge clk);
         end
      end
   end
endmodule : proc_model
`default_nettype wire

// file: dv/daisy_chain_priority_interrupt_bench.sv
/* Bench for the interrupt board with a processor model.
   Assumes board id fixed, open-drain request with pull-up. */
`timescale 1ns/1ps
`default_nettype none
module daisy_chain_priority_interrupt_bench;
   import prio_intr_pkg::*;
   logic clk = 1'b0, reset = 1'b1, prio_in = 1'b0, oe_q = 1'b0;
   line_vec_t lines = 8'h00, en = 8'h00, p, e;
   logic [2:0] bid = 3'h5;
   logic ack, strobe, prio_out, req_out, req_oe, bus_oe, busy, req_n;
   byte_t bus_data;
   byte_t expq[$];
   int errors = 0, total_checks = 0, n;
   assign req_n = ~req_oe;
   always #12.5 clk = ~clk;
   prio_intr_board DUT (.CLK(clk), .RESET(reset), .IRQ_LINES(lines), .IRQ_ENABLE(en),
      .BOARD_ID(bid), .PRIO_IN(prio_in), .PRIO_OUT(prio_out), .IRQ_REQ_IN(req_n),
      .IRQ_REQ_OUT(req_out), .IRQ_REQ_OE(req_oe), .ACK(ack), .ADDR_STROBE(strobe),
      .BUS_DATA(bus_data), .BUS_OE(bus_oe), .BUSY(busy));
   proc_model PARTNER (.clk(clk), .req_n(req_n), .ack(ack), .strobe(strobe));
   task automatic check(input byte_t seen, input byte_t exp);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("Error %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task finish_test;
      if (errors == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : finish_test
   // Compare each address byte with the oldest note
   always @(posedge clk) begin
      if (bus_oe === 1'b1 && oe_q !== 1'b1) begin
         if (expq.size() == 0) check(bus_data, 8'hff);
         else check(bus_data, expq.pop_front());
      end
      oe_q <= bus_oe;
   end
   // Stimulus: inputs pulsed together, services expected lowest index first
   initial begin
      void'($urandom(32'h9c1e));
      e = 8'($urandom) | 8'h81;
      p = 8'h81;
      repeat (8) @(posedge clk);
      reset <= 1'b0;
      en <= e;
      lines <= p;
      repeat (2) @(posedge clk);
      lines <= 8'h00;
      repeat (12) @(posedge clk);
      check({5'h00, req_out, prio_out, req_oe}, 8'h00);
      prio_in <= 1'b1;
      for (int r = 0; r < 12; r++) begin
         if (r > 0) begin
            p = 8'($urandom);
            lines <= p;
            repeat (2) @(posedge clk);
            lines <= 8'h00;
         end
         for (int i = 0; i < 8; i++) if (p[i] & e[i]) expq.push_back({2'b00, bid, i[2:0]});
         n = 0;
         while ((expq.size() > 0 || busy !== 1'b0) && n < 400) begin
            @(posedge clk);
            n++;
         end
         if (n == 400) begin
            errors++;
            break;
         end
         repeat (4) @(posedge clk);
         check({7'h00, prio_out}, 8'h01);
      end
      finish_test;
   end
endmodule : daisy_chain_priority_interrupt_bench
`default_nettype wire
